// ---- emulated_line_interface_pkg.sv ----
// Purpose: shared constants for the emulated line interface register subset
// Assumes: 32-bit memory-mapped words, 16-bit serial management words
// Notes: offsets are byte addresses
package emulated_line_interface_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_ID_HIGH = 12'h01C8;
  localparam logic [11:0] OFS_ID_LOW = 12'h01CC;
  localparam logic [11:0] OFS_AN_ADV = 12'h01D0;
  localparam logic [11:0] OFS_PARTNER = 12'h01D4;
  // serial management register indices
  localparam logic [4:0] IDX_CONTROL = 5'h00;
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_ID_HIGH = 5'h02;
  localparam logic [4:0] IDX_ID_LOW = 5'h03;
  localparam logic [4:0] IDX_AN_ADV = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;
  localparam logic [4:0] IDX_LAST = 5'h06;
  // advertisement field positions
  localparam int ADV_PAUSE_LSB = 10;
  localparam int ADV_ABIL_LSB = 5;
  localparam int ADV_SEL_LSB = 0;
  localparam logic [15:0] ID_HIGH_RESET = 16'h0000;
  localparam logic [15:0] ID_LOW_RESET = 16'h0000;
  localparam logic [1:0] PAUSE_STRAP_LOW = 2'h3;
  localparam logic [1:0] PAUSE_STRAP_HIGH = 2'h0;
  localparam logic [3:0] ABIL_RESET = 4'hF;
  localparam logic [4:0] SEL_IEEE_8023 = 5'h01;
  // status: all four abilities, link up, extended capability; no fault, no jabber
  localparam logic [15:0] STATUS_VALUE = 16'h7805;
  // serial frame figures
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [5:0] HEADER_BITS = 6'h0D;
  localparam logic [5:0] TURN_BITS = 6'h02;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
endpackage

// ---- emulated_line_interface_regs.sv ----
// Purpose: identifier, advertisement and partner ability registers of the emulated line
// Assumes: synchronous inputs, one access per cycle on the memory-mapped port
// Notes: memory-mapped reads answer one cycle later; serial writes lose to a same-cycle mm write
`timescale 1ns/1ps
`default_nettype none
module emulated_line_interface_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic flow_control_default_strap_i,
  input wire logic [emulated_line_interface_pkg::ADDR_W-1:0] mm_addr_i,
  input wire logic mm_write_i,
  input wire logic mm_read_i,
  input wire logic [31:0] mm_wdata_i,
  output logic [31:0] mm_rdata_o,
  input wire logic [4:0] phy_address_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o
);
  import emulated_line_interface_pkg::*;

  logic [15:0] phy_identifier_high;
  logic [15:0] phy_identifier_low;
  logic [1:0] adv_pause;
  logic [3:0] adv_ability;
  logic [4:0] adv_selector;
  logic [4:0] mii_index;
  logic mii_write;
  logic [15:0] mii_wdata;

  // one write port per cycle; memory-mapped access has priority
  wire mm_hit_high = mm_addr_i == OFS_ID_HIGH;
  wire mm_hit_low = mm_addr_i == OFS_ID_LOW;
  wire mm_hit_adv = mm_addr_i == OFS_AN_ADV;
  wire mm_hit_partner = mm_addr_i == OFS_PARTNER;
  wire [15:0] wr_data = mm_write_i ? mm_wdata_i[15:0] : mii_wdata;
  wire wr_high = (mm_write_i && mm_hit_high) || (!mm_write_i && mii_write && mii_index == IDX_ID_HIGH);
  wire wr_low = (mm_write_i && mm_hit_low) || (!mm_write_i && mii_write && mii_index == IDX_ID_LOW);
  wire wr_adv = (mm_write_i && mm_hit_adv) || (!mm_write_i && mii_write && mii_index == IDX_AN_ADV);

  wire [15:0] autoneg_advertisement = {4'h0, adv_pause, 1'b0, adv_ability, adv_selector};
  // emulated partner mirrors our own abilities
  wire [15:0] partner_base_ability = {4'h0, adv_pause, 1'b0, adv_ability, SEL_IEEE_8023};

  wire [15:0] mm_word = mm_hit_high ? phy_identifier_high :
                        mm_hit_low ? phy_identifier_low :
                        mm_hit_adv ? autoneg_advertisement :
                        mm_hit_partner ? partner_base_ability : 16'h0000;

  wire [15:0] mii_rd_data = (mii_index == IDX_STATUS) ? STATUS_VALUE :
                            (mii_index == IDX_ID_HIGH) ? phy_identifier_high :
                            (mii_index == IDX_ID_LOW) ? phy_identifier_low :
                            (mii_index == IDX_AN_ADV) ? autoneg_advertisement :
                            (mii_index == IDX_PARTNER) ? partner_base_ability :
                            16'h0000;

  serial_management_engine u_engine (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .phy_address_i(phy_address_i),
    .rd_data_i(mii_rd_data),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .reg_index_o(mii_index),
    .wr_o(mii_write),
    .wr_data_o(mii_wdata)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phy_identifier_high <= ID_HIGH_RESET;
      phy_identifier_low <= ID_LOW_RESET;
      adv_pause <= flow_control_default_strap_i ? PAUSE_STRAP_HIGH : PAUSE_STRAP_LOW;
      adv_ability <= ABIL_RESET;
      adv_selector <= SEL_IEEE_8023;
    end else begin
      if (wr_high) begin
        phy_identifier_high <= wr_data;
      end
      if (wr_low) begin
        phy_identifier_low <= wr_data;
      end
      if (wr_adv) begin
        adv_pause <= wr_data[ADV_PAUSE_LSB +: 2];
        adv_ability <= wr_data[ADV_ABIL_LSB +: 4];
        adv_selector <= wr_data[ADV_SEL_LSB +: 5];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mm_rdata_o <= 32'h0000_0000;
    end else if (mm_read_i) begin
      mm_rdata_o <= {16'h0000, mm_word};
    end
  end

  property p_id_high_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_write_i && mm_hit_high) |=> phy_identifier_high == $past(mm_wdata_i[15:0]);
  endproperty
  a_id_high_write: assert property (p_id_high_write) else $error("upper id not stored");

  property p_pad_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    mm_read_i |=> mm_rdata_o[31:16] == 16'h0000;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("padding bits not zero");

  property p_serial_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mii_write && !mm_write_i && mii_index == IDX_ID_LOW) |=> phy_identifier_low == $past(mii_wdata);
  endproperty
  a_serial_write: assert property (p_serial_write) else $error("serial write lost");

  property p_id_low_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_write_i && mm_hit_low) |=> phy_identifier_low == $past(mm_wdata_i[15:0]);
  endproperty
  a_id_low_write: assert property (p_id_low_write) else $error("lower id not stored");

  property p_next_page_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_read_i && mm_hit_adv) |=> !mm_rdata_o[15];
  endproperty
  a_next_page_zero: assert property (p_next_page_zero) else $error("next page set");

  property p_fault_reserved_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_read_i && mm_hit_adv) |=> mm_rdata_o[14:12] == 3'h0;
  endproperty
  a_fault_reserved_zero: assert property (p_fault_reserved_zero) else $error("bits 14:12 set");

  property p_pause_strap;
    @(posedge clk_i) $rose(reset_n_i) |->
      adv_pause == ($past(flow_control_default_strap_i) ? PAUSE_STRAP_HIGH : PAUSE_STRAP_LOW);
  endproperty
  a_pause_strap: assert property (p_pause_strap) else $error("pause default wrong");

  property p_t4_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_read_i && mm_hit_adv) |=> !mm_rdata_o[9];
  endproperty
  a_t4_zero: assert property (p_t4_zero) else $error("bit 9 set");

  property p_ability_reset;
    @(posedge clk_i) $rose(reset_n_i) |-> adv_ability == ABIL_RESET && adv_selector == SEL_IEEE_8023;
  endproperty
  a_ability_reset: assert property (p_ability_reset) else $error("ability reset wrong");

  property p_partner_read_only;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_write_i && mm_hit_partner) |=> $stable(partner_base_ability);
  endproperty
  a_partner_read_only: assert property (p_partner_read_only) else $error("partner changed");

  sequence s_zero_written;
    mm_write_i && mm_hit_high && mm_wdata_i[15:0] == 16'h0000 ##[1:2] mm_read_i && mm_hit_high;
  endsequence
  property p_zero_kept;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_zero_written |=> mm_rdata_o == 32'h0000_0000;
  endproperty
  a_zero_kept: assert property (p_zero_kept) else $error("zero id not kept");

  property p_upper_index_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mii_index > IDX_LAST) |-> mii_rd_data == 16'h0000;
  endproperty
  a_upper_index_zero: assert property (p_upper_index_zero) else $error("index above 6 nonzero");

  property p_link_up;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mii_index == IDX_STATUS) |-> mii_rd_data[2] && !mii_rd_data[1] && !mii_rd_data[4];
  endproperty
  a_link_up: assert property (p_link_up) else $error("status link wrong");

  property p_adv_write_isolated;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_write_i && mm_hit_adv) |=> $stable(phy_identifier_high) && $stable(phy_identifier_low);
  endproperty
  a_adv_write_isolated: assert property (p_adv_write_isolated) else $error("neighbour changed");

  property p_pause_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_write_i && mm_hit_adv) |=> adv_pause == $past(mm_wdata_i[ADV_PAUSE_LSB +: 2]);
  endproperty
  a_pause_write: assert property (p_pause_write) else $error("pause bits not stored");

  property p_ability_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mm_write_i && mm_hit_adv) |=> adv_ability == $past(mm_wdata_i[ADV_ABIL_LSB +: 4]) &&
      adv_selector == $past(mm_wdata_i[ADV_SEL_LSB +: 5]);
  endproperty
  a_ability_write: assert property (p_ability_write) else $error("ability or selector lost");

  property p_serial_adv_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (mii_write && !mm_write_i && mii_index == IDX_AN_ADV) |=>
      adv_pause == $past(mii_wdata[ADV_PAUSE_LSB +: 2]) &&
      adv_ability == $past(mii_wdata[ADV_ABIL_LSB +: 4]);
  endproperty
  a_serial_adv_write: assert property (p_serial_adv_write) else $error("serial adv lost");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    !mm_read_i |=> $stable(mm_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
endmodule
`default_nettype wire

// ---- mgmt_host_model.sv ----
// Purpose: management host that runs serial management frames against the device
// Assumes: clk_i is the device clock; mdc half period is five clk_i cycles
// Notes: mdc stands low between frames; a released line is pulled up
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic clk_i,
  input wire logic mdio_line_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
  end

  // one frame: 32 preamble ones, start, op, address, index, turnaround, 16 data bits
  task automatic frame(input logic [1:0] op, input logic [4:0] idx, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] bits;
    logic is_read;
    bits = {32'hFFFF_FFFF, 2'b01, op, PHY_ADDR, idx, 2'b10, wd};
    is_read = (op == 2'h2);
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_i);
      mdc_o <= 1'b0;
      // reads release the line from the turnaround on
      mdio_oe_o <= !(is_read && i < 18);
      mdio_o <= bits[i];
      repeat (5) @(posedge clk_i);
      mdc_o <= 1'b1;
      rd = {rd[14:0], mdio_line_i};
      repeat (4) @(posedge clk_i);
    end
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- serial_management_engine.sv ----
// Purpose: serial management frame engine, 16-bit register words
// Assumes: mdc_i and mdio_i synchronous to clk_i, clk_i much faster than mdc_i
// Notes: all bits are taken and launched at the rising edge of mdc_i
`timescale 1ns/1ps
`default_nettype none
module serial_management_engine (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic [4:0] phy_address_i,
  input wire logic [15:0] rd_data_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic [4:0] reg_index_o,
  output logic wr_o,
  output logic [15:0] wr_data_o
);
  import emulated_line_interface_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_HEADER = 5'b00010,
    S_TURN = 5'b00100,
    S_READ = 5'b01000,
    S_WRITE = 5'b10000
  } engine_state_t;

  engine_state_t state;
  logic mdc_prev;
  logic [5:0] count;
  logic [12:0] header;
  logic [15:0] shift;
  logic is_read;

  wire mdc_rise = mdc_i & ~mdc_prev;
  wire [5:0] count_inc = count + 6'h01;
  wire [12:0] next_header = {header[11:0], mdio_i};
  wire header_start_ok = next_header[12];
  wire [1:0] header_op = next_header[11:10];
  wire header_match = header_start_ok && (next_header[9:5] == phy_address_i);
  wire header_read = header_match && (header_op == OP_READ);
  wire header_write = header_match && (header_op == OP_WRITE);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mdc_prev <= 1'b0;
      state <= S_IDLE;
      count <= 6'h00;
      header <= 13'h0000;
      shift <= 16'h0000;
      is_read <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      reg_index_o <= 5'h00;
      wr_o <= 1'b0;
      wr_data_o <= 16'h0000;
    end else begin
      mdc_prev <= mdc_i;
      wr_o <= 1'b0;
      if (mdc_rise) begin
        unique case (state)
          S_IDLE: begin
            if (mdio_i) begin
              count <= (count == PREAMBLE_ONES) ? count : count_inc;
            end else if (count == PREAMBLE_ONES) begin
              state <= S_HEADER;
              count <= 6'h00;
            end else begin
              count <= 6'h00;
            end
          end
          S_HEADER: begin
            header <= next_header;
            count <= count_inc;
            if (count_inc == HEADER_BITS) begin
              count <= 6'h00;
              reg_index_o <= next_header[4:0];
              is_read <= header_read;
              state <= (header_read || header_write) ? S_TURN : S_IDLE;
            end
          end
          S_TURN: begin
            count <= count_inc;
            if (is_read && count == 6'h00) begin
              mdio_o <= 1'b0;
              mdio_oe_o <= 1'b1;
            end
            if (count_inc == TURN_BITS) begin
              count <= 6'h00;
              if (is_read) begin
                shift <= {rd_data_i[14:0], 1'b0};
                mdio_o <= rd_data_i[15];
                state <= S_READ;
              end else begin
                state <= S_WRITE;
              end
            end
          end
          S_READ: begin
            count <= count_inc;
            mdio_o <= shift[15];
            shift <= {shift[14:0], 1'b0};
            if (count_inc == DATA_BITS) begin
              mdio_o <= 1'b0;
              mdio_oe_o <= 1'b0;
              count <= 6'h00;
              state <= S_IDLE;
            end
          end
          S_WRITE: begin
            count <= count_inc;
            shift <= {shift[14:0], mdio_i};
            if (count_inc == DATA_BITS) begin
              wr_o <= 1'b1;
              wr_data_o <= {shift[14:0], mdio_i};
              count <= 6'h00;
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: register and serial access tests of the emulated line register subset
// Assumes: 200 MHz clock, synchronous active-low reset held for 20 cycles
// Notes: expected words are built from the field layout, never read back from the design
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import emulated_line_interface_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  logic [ADDR_W-1:0] mm_addr = '0;
  logic mm_write = 1'b0;
  logic mm_read = 1'b0;
  logic [31:0] mm_wdata = 32'h0000_0000;
  logic [31:0] mm_rdata;
  logic dev_mdio, dev_oe, host_mdc, host_mdio, host_oe, mdio_line;
  logic [15:0] sv;
  int n_mismatch = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;
  // pulled-up shared data line
  assign mdio_line = dev_oe ? dev_mdio : (host_oe ? host_mdio : 1'b1);

  emulated_line_interface_regs uut (.clk_i(clk), .reset_n_i(reset_n),
    .flow_control_default_strap_i(strap), .mm_addr_i(mm_addr), .mm_write_i(mm_write),
    .mm_read_i(mm_read), .mm_wdata_i(mm_wdata), .mm_rdata_o(mm_rdata),
    .phy_address_i(5'h01), .mdc_i(host_mdc), .mdio_i(mdio_line), .mdio_o(dev_mdio),
    .mdio_oe_o(dev_oe));
  mgmt_host_model #(.PHY_ADDR(5'h01)) host (.clk_i(clk), .mdio_line_i(mdio_line),
    .mdc_o(host_mdc), .mdio_o(host_mdio), .mdio_oe_o(host_oe));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic mm_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    mm_addr <= a;
    mm_wdata <= d;
    mm_write <= 1'b1;
    @(posedge clk);
    mm_write <= 1'b0;
  endtask
  task automatic expect_mm(input string what, input logic [ADDR_W-1:0] a,
                           input logic [31:0] exp);
    @(posedge clk);
    mm_addr <= a;
    mm_read <= 1'b1;
    @(posedge clk);
    mm_read <= 1'b0;
    #1;
    check(what, mm_rdata, exp);
  endtask
  task automatic expect_ser(input string what, input logic [4:0] idx, input logic [15:0] exp);
    logic [15:0] v;
    host.frame(OP_READ, idx, 16'h0000, v);
    check(what, {16'h0000, v}, {16'h0000, exp});
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    strap <= s;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    do_reset(1'b0);
    expect_mm("id high reset", OFS_ID_HIGH, 32'h0000_0000);
    expect_mm("id low reset", OFS_ID_LOW, 32'h0000_0000);
    expect_mm("adv reset strap low", OFS_AN_ADV, 32'h0000_0DE1);
    expect_mm("partner reset", OFS_PARTNER, 32'h0000_0DE1);
    expect_mm("unmapped word", 12'h1D8, 32'h0000_0000);
    $display("test reset_values done");

    mm_wr(OFS_ID_HIGH, 32'hFFFF_FFFF);
    expect_mm("id high ones", OFS_ID_HIGH, 32'h0000_FFFF);
    mm_wr(OFS_ID_LOW, 32'hFFFF_FFFF);
    expect_mm("id low ones", OFS_ID_LOW, 32'h0000_FFFF);
    expect_mm("id high padding", OFS_ID_HIGH, 32'h0000_FFFF);
    mm_wr(OFS_ID_HIGH, 32'h0000_0000);
    expect_mm("id high zero", OFS_ID_HIGH, 32'h0000_0000);
    mm_wr(OFS_ID_LOW, 32'h0000_0000);
    expect_mm("id low zero", OFS_ID_LOW, 32'h0000_0000);
    // selector kept at the IEEE 802.3 code in every write
    mm_wr(OFS_AN_ADV, 32'hFFFF_FFE1);
    expect_mm("adv fixed bits", OFS_AN_ADV, 32'h0000_0DE1);
    for (int i = 5; i <= 8; i++) begin
      mm_wr(OFS_AN_ADV, 32'h0000_0DE1 & ~(32'h0000_0001 << i));
      expect_mm("ability withdrawn", OFS_AN_ADV, 32'h0000_0DE1 & ~(32'h0000_0001 << i));
    end
    mm_wr(OFS_AN_ADV, 32'h0000_0001);
    expect_mm("adv all cleared", OFS_AN_ADV, 32'h0000_0001);
    mm_wr(OFS_PARTNER, 32'hFFFF_FFFF);
    expect_mm("partner read only", OFS_PARTNER, 32'h0000_0001);
    $display("test mm_access done");

    do_reset(1'b1);
    expect_mm("adv reset strap high", OFS_AN_ADV, 32'h0000_01E1);
    $display("test strap_high done");

    mm_wr(OFS_ID_LOW, 32'h0000_A5C3);
    expect_ser("serial id low", IDX_ID_LOW, 16'hA5C3);
    expect_ser("serial status", IDX_STATUS, 16'h7805);
    expect_ser("serial control", IDX_CONTROL, 16'h0000);
    expect_ser("serial index 6", IDX_LAST, 16'h0000);
    expect_ser("serial index 7", 5'h07, 16'h0000);
    host.frame(OP_WRITE, IDX_ID_HIGH, 16'h5A3C, sv);
    repeat (4) @(posedge clk);
    expect_mm("serial write id high", OFS_ID_HIGH, 32'h0000_5A3C);
    host.frame(OP_WRITE, IDX_AN_ADV, 16'hF3E1, sv);
    repeat (4) @(posedge clk);
    expect_mm("serial write adv", OFS_AN_ADV, 32'h0000_01E1);
    expect_ser("serial read adv", IDX_AN_ADV, 16'h01E1);
    $display("test serial_access done");
    report_and_stop();
  end
endmodule
`default_nettype wire
